// [timer_one_pkg.sv]
package timer_one_pkg;

    // Core clock is the oscillator; the internal count clock is a quarter of it
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned INTERNAL_DIV   = 4;
    localparam logic [1:0]  INTERNAL_LAST  = 2'(INTERNAL_DIV - 1);

    // Register indices; byte address is four times the index
    localparam logic [5:0]  IDX_COUNT_LOW  = 6'h0E;
    localparam logic [5:0]  IDX_COUNT_HIGH = 6'h0F;
    localparam logic [5:0]  IDX_CONTROL    = 6'h10;
    localparam logic [5:0]  IDX_STATUS     = 6'h11;

    // Control register fields
    localparam int unsigned RUN_BIT        = 0;
    localparam int unsigned SOURCE_BIT     = 1;
    localparam int unsigned BYPASS_BIT     = 2;
    localparam int unsigned OSC_BIT        = 3;
    localparam int unsigned DIV_LSB        = 4;
    localparam int unsigned DIV_MSB        = 5;
    localparam logic [7:0]  CONTROL_RESET  = 8'h00;
    localparam logic [7:0]  CONTROL_MASK   = 8'h3F;

    // Status register field and count reset and maximum values
    localparam int unsigned FLAG_BIT       = 0;
    localparam logic [15:0] COUNT_RESET    = 16'h0000;
    localparam logic [15:0] COUNT_MAX      = 16'hFFFF;

    // Prescaler depth: three ripple stages give up to divide by 8
    localparam int unsigned PRESCALE_BITS  = 3;

endpackage

// [count_prescaler.sv]
`timescale 1ns/1ps
`default_nettype none
module count_prescaler (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       in_tick,
    input  wire logic       clear,
    input  wire logic [1:0] divide_select,
    output logic            out_tick,
    output logic            out_toggle
);
    logic [timer_one_pkg::PRESCALE_BITS-1:0] stage_q;
    logic [timer_one_pkg::PRESCALE_BITS:0]   carry;
    logic                                    out_tick_q;
    logic                                    out_toggle_q;

    assign carry[0] = in_tick;

    // Stage 0 flips on the input tick, each later stage on the carry out of the one below it
    genvar i;
    generate
        for (i = 0; i < timer_one_pkg::PRESCALE_BITS; i++) begin : g_stage
            assign carry[i+1] = carry[i] & stage_q[i];
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    stage_q[i] <= 1'b0;
                end else if (clear) begin
                    stage_q[i] <= 1'b0;
                end else if (carry[i]) begin
                    stage_q[i] <= ~stage_q[i];
                end
            end
        end
    endgenerate

    // Tap the carry selected by the divide code
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            out_tick_q   <= 1'b0;
            out_toggle_q <= 1'b0;
        end else begin
            out_tick_q <= carry[divide_select] & ~clear;
            if (carry[divide_select] & ~clear) begin
                out_toggle_q <= ~out_toggle_q;
            end
        end
    end

    assign out_tick   = out_tick_q;
    assign out_toggle = out_toggle_q;

    div_two_a: assert property (@(posedge core_clk) disable iff (rst)
        (divide_select == 2'b01) && out_tick_q && !clear && !$past(clear) |-> !stage_q[0])
        else $error("divide by two output not on second input");

    clear_a: assert property (@(posedge core_clk) disable iff (rst)
        clear |=> (stage_q == '0) && !out_tick_q)
        else $error("prescaler not cleared");
endmodule
`default_nettype wire

// [edge_synchronizer.sv]
`timescale 1ns/1ps
`default_nettype none
module edge_synchronizer (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic in_level,
    input  wire logic enable,
    output logic      out_pulse
);
    logic meta_q;
    logic stable_q;
    logic last_q;
    logic pulse_q;

    // Chain freezes while disabled and the pulse output is held low, as the phase clocks stop in sleep
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_q   <= 1'b0;
            stable_q <= 1'b0;
            last_q   <= 1'b0;
            pulse_q  <= 1'b0;
        end else if (enable) begin
            meta_q   <= in_level;
            stable_q <= meta_q;
            last_q   <= stable_q;
            pulse_q  <= stable_q ^ last_q;
        end else begin
            pulse_q  <= 1'b0;
        end
    end

    assign out_pulse = pulse_q;

    frozen_a: assert property (@(posedge core_clk) disable iff (rst)
        !enable |=> !pulse_q && $stable(stable_q))
        else $error("synchronizer moved while disabled");
endmodule
`default_nettype wire

// [sixteen_bit_counter.sv]
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sixteen_bit_counter (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        ext_clock_pin,
    input  wire logic        crystal_input_pin,
    output logic             crystal_output_pin_o,
    output logic             crystal_output_pin_oe,
    input  wire logic        sleep_mode,
    output logic             overflow_flag,
    output logic             wake_request,
    output logic             timebase_valid
);
    logic [7:0]  control_q;
    logic [15:0] count_q;
    logic        flag_q;
    logic        ack_q;
    logic [31:0] dat_q;
    logic [1:0]  int_div_q;
    logic        ext_q;
    logic        ext_prev_q;
    logic        armed_q;
    logic        xtal_out_q;
    logic        xtal_oe_q;
    logic        wake_q;
    logic        timebase_q;

    logic        counter_run;
    logic        clock_source_select;
    logic        ext_sync_bypass;
    logic        crystal_osc_enable;
    logic [1:0]  input_divide_select;
    logic        async_mode;
    logic        sync_mode;

    logic        bus_req;
    logic        bus_write;
    logic [5:0]  word_idx;
    logic        write_low;
    logic        write_high;
    logic        write_control;
    logic        flag_clear;
    logic        count_write;
    logic [7:0]  read_byte;

    logic        int_tick;
    logic        ext_level;
    logic        ext_rise;
    logic        ext_fall;
    logic        src_tick;
    logic        pre_tick;
    logic        pre_toggle;
    logic        sync_pulse;
    logic        inc;
    logic        ovf_evt;

    assign counter_run         = control_q[timer_one_pkg::RUN_BIT];
    assign clock_source_select = control_q[timer_one_pkg::SOURCE_BIT];
    assign ext_sync_bypass     = control_q[timer_one_pkg::BYPASS_BIT];
    assign crystal_osc_enable  = control_q[timer_one_pkg::OSC_BIT];
    assign input_divide_select = control_q[timer_one_pkg::DIV_MSB:timer_one_pkg::DIV_LSB];

    // Bypass only matters with the external source selected
    assign async_mode = clock_source_select & ext_sync_bypass;
    assign sync_mode  = clock_source_select & ~ext_sync_bypass;

    // Wishbone decode; a write lands on the edge where ack is sampled
    assign bus_req       = wb_cyc_i & wb_stb_i;
    assign bus_write     = bus_req & ack_q & wb_we_i & wb_sel_i[0];
    assign word_idx      = wb_adr_i[7:2];
    assign write_low     = bus_write & (word_idx == timer_one_pkg::IDX_COUNT_LOW);
    assign write_high    = bus_write & (word_idx == timer_one_pkg::IDX_COUNT_HIGH);
    assign write_control = bus_write & (word_idx == timer_one_pkg::IDX_CONTROL);
    assign flag_clear    = bus_write & (word_idx == timer_one_pkg::IDX_STATUS)
                         & wb_dat_i[timer_one_pkg::FLAG_BIT];
    assign count_write   = write_low | write_high;

    always_comb begin
        read_byte = 8'h00;
        unique case (word_idx)
            timer_one_pkg::IDX_COUNT_LOW:  read_byte = count_q[7:0];
            timer_one_pkg::IDX_COUNT_HIGH: read_byte = count_q[15:8];
            timer_one_pkg::IDX_CONTROL:    read_byte = control_q;
            timer_one_pkg::IDX_STATUS:     read_byte = {7'h00, flag_q};
            default:                       read_byte = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req & ~ack_q;
        end
    end

    // Count is a plain register on the core clock, so a byte is never torn
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dat_q <= 32'h0000_0000;
        end else if (bus_req & ~ack_q) begin
            dat_q <= {24'h00_0000, read_byte};
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            control_q <= timer_one_pkg::CONTROL_RESET;
        end else if (write_control) begin
            control_q <= wb_dat_i[7:0] & timer_one_pkg::CONTROL_MASK;
        end
    end

    // Quarter-rate internal clock; stops with the core in sleep
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            int_div_q <= 2'b00;
        end else if (!sleep_mode) begin
            int_div_q <= int_div_q + 2'b01;
        end
    end

    assign int_tick = ~sleep_mode & (int_div_q == timer_one_pkg::INTERNAL_LAST);

    // Crystal input feeds the counter when the oscillator is on
    assign ext_level = crystal_osc_enable ? crystal_input_pin : ext_clock_pin;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ext_q      <= 1'b0;
            ext_prev_q <= 1'b0;
        end else begin
            ext_q      <= ext_level;
            ext_prev_q <= ext_q;
        end
    end

    assign ext_rise = ext_q & ~ext_prev_q;
    assign ext_fall = ~ext_q & ext_prev_q;

    // A pin already high at enable must not count as a rising edge
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            armed_q <= 1'b0;
        end else if (!counter_run || !clock_source_select) begin
            armed_q <= 1'b0;
        end else if (ext_fall) begin
            armed_q <= 1'b1;
        end
    end

    // Source mux: quarter clock or armed rising edges only
    assign src_tick = counter_run
                    & (clock_source_select ? (armed_q & ext_rise) : int_tick);

    count_prescaler u_prescaler (
        .core_clk      (core_clk),
        .rst           (rst),
        .in_tick       (src_tick),
        .clear         (count_write),
        .divide_select (input_divide_select),
        .out_tick      (pre_tick),
        .out_toggle    (pre_toggle)
    );

    // Prescaler output, not the raw pin, crosses the synchronizer
    edge_synchronizer u_sync (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_level  (pre_toggle),
        .enable    (~sleep_mode),
        .out_pulse (sync_pulse)
    );

    // A tick arriving just as run drops is discarded, never half applied
    assign inc     = counter_run & (sync_mode ? sync_pulse : pre_tick);
    assign ovf_evt = inc & ~count_write & (count_q == timer_one_pkg::COUNT_MAX);

    // Writes win over an increment in the same cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count_q <= timer_one_pkg::COUNT_RESET;
        end else if (write_low) begin
            count_q[7:0] <= wb_dat_i[7:0];
        end else if (write_high) begin
            count_q[15:8] <= wb_dat_i[7:0];
        end else if (inc) begin
            count_q <= count_q + 16'h0001;
        end
    end

    // Set beats a clear arriving in the same cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (ovf_evt) begin
            flag_q <= 1'b1;
        end else if (flag_clear) begin
            flag_q <= 1'b0;
        end
    end

    // Inverter held off when disabled; sleep does not touch it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            xtal_out_q <= 1'b0;
            xtal_oe_q  <= 1'b0;
        end else begin
            xtal_oe_q  <= crystal_osc_enable;
            xtal_out_q <= crystal_osc_enable & ~crystal_input_pin;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wake_q     <= 1'b0;
            timebase_q <= 1'b1;
        end else begin
            wake_q     <= sleep_mode & async_mode & flag_q;
            timebase_q <= ~async_mode;
        end
    end

    assign wb_ack_o              = ack_q;
    assign wb_dat_o              = dat_q;
    assign crystal_output_pin_o  = xtal_out_q;
    assign crystal_output_pin_oe = xtal_oe_q;
    assign overflow_flag         = flag_q;
    assign wake_request          = wake_q;
    assign timebase_valid        = timebase_q;

    bus_ack_a: assert property (@(posedge core_clk) disable iff (rst)
        bus_req && !ack_q |=> ack_q ##1 !ack_q)
        else $error("ack not a single cycle after request");

    ovf_flag_a: assert property (@(posedge core_clk) disable iff (rst)
        ovf_evt |=> flag_q && (count_q == timer_one_pkg::COUNT_RESET))
        else $error("rollover did not zero count and set flag");

    run_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        !counter_run && !count_write |=> $stable(count_q))
        else $error("count moved while stopped");

    sleep_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        sync_mode && sleep_mode && $past(sleep_mode) |-> !inc)
        else $error("synchronized count advanced in sleep");

    arm_first_a: assert property (@(posedge core_clk) disable iff (rst)
        clock_source_select && !armed_q && ext_rise |=> !pre_tick)
        else $error("rising edge counted before a falling edge");

    low_write_a: assert property (@(posedge core_clk) disable iff (rst)
        write_low |=> count_q[7:0] == $past(wb_dat_i[7:0]))
        else $error("low byte write lost");

    xtal_off_a: assert property (@(posedge core_clk) disable iff (rst)
        !crystal_osc_enable |=> !crystal_output_pin_oe && !crystal_output_pin_o)
        else $error("crystal driver active while disabled");

    reserved_a: assert property (@(posedge core_clk) disable iff (rst)
        write_control |=> control_q[7:6] == 2'b00)
        else $error("reserved control bits set");

    wake_cause_a: assert property (@(posedge core_clk) disable iff (rst)
        wake_request |-> $past(async_mode && sleep_mode && flag_q))
        else $error("wake without async overflow in sleep");

    timebase_a: assert property (@(posedge core_clk) disable iff (rst)
        async_mode |=> !timebase_valid)
        else $error("async counter offered as timebase");
endmodule
`default_nettype wire

// [count_source.sv]
`timescale 1ns/1ps
`default_nettype none
module count_source #(
    parameter int unsigned HALF = 4
) (
    input  wire logic core_clk,
    output logic      ext_clock_pin,
    output logic      crystal_input_pin
);
    // Gated source: the clock stands still between bursts
    initial begin
        ext_clock_pin = 1'b0;
        crystal_input_pin = 1'b0;
    end

    task automatic set_level(input logic xtal, input logic v);
        @(posedge core_clk);
        if (xtal) begin
            crystal_input_pin <= v;
        end else begin
            ext_clock_pin <= v;
        end
        repeat (HALF) @(posedge core_clk);
    endtask

    // Each pulse is a falling then a rising edge
    task automatic pulse(input logic xtal, input int n);
        for (int i = 0; i < n; i++) begin
            set_level(xtal, 1'b0);
            set_level(xtal, 1'b1);
        end
    endtask
endmodule
`default_nettype wire

// [test_sixteen_bit_counter.sv]
`timescale 1ns/1ps
`default_nettype none
module test_sixteen_bit_counter;
    localparam logic [7:0] A_LOW  = {timer_one_pkg::IDX_COUNT_LOW, 2'b00};
    localparam logic [7:0] A_HIGH = {timer_one_pkg::IDX_COUNT_HIGH, 2'b00};
    localparam logic [7:0] A_CTRL = {timer_one_pkg::IDX_CONTROL, 2'b00};
    localparam logic [7:0] A_STAT = {timer_one_pkg::IDX_STATUS, 2'b00};

    logic        core_clk   = 1'b0;
    logic        rst        = 1'b1;
    logic        wb_cyc_i   = 1'b0;
    logic        wb_stb_i   = 1'b0;
    logic        wb_we_i    = 1'b0;
    logic [7:0]  wb_adr_i   = 8'h00;
    logic [3:0]  wb_sel_i   = 4'h0;
    logic [31:0] wb_dat_i   = 32'h0000_0000;
    logic        sleep_mode = 1'b0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    wire         ext_clock_pin;
    wire         crystal_input_pin;
    logic        crystal_output_pin_o;
    logic        crystal_output_pin_oe;
    logic        overflow_flag;
    logic        wake_request;
    logic        timebase_valid;
    int          n_fail       = 0;
    int          total_checks = 0;
    logic [31:0] v;
    logic [31:0] w;
    logic [31:0] u;
    logic [15:0] pair;

    always #5 core_clk = ~core_clk;

    count_source src (
        .core_clk          (core_clk),
        .ext_clock_pin     (ext_clock_pin),
        .crystal_input_pin (crystal_input_pin)
    );

    sixteen_bit_counter DUT (
        .core_clk              (core_clk),
        .rst                   (rst),
        .wb_cyc_i              (wb_cyc_i),
        .wb_stb_i              (wb_stb_i),
        .wb_we_i               (wb_we_i),
        .wb_adr_i              (wb_adr_i),
        .wb_sel_i              (wb_sel_i),
        .wb_dat_i              (wb_dat_i),
        .wb_dat_o              (wb_dat_o),
        .wb_ack_o              (wb_ack_o),
        .ext_clock_pin         (ext_clock_pin),
        .crystal_input_pin     (crystal_input_pin),
        .crystal_output_pin_o  (crystal_output_pin_o),
        .crystal_output_pin_oe (crystal_output_pin_oe),
        .sleep_mode            (sleep_mode),
        .overflow_flag         (overflow_flag),
        .wake_request          (wake_request),
        .timebase_valid        (timebase_valid)
    );

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Holds the request until ack is sampled high; data taken at that edge
    // No cycle limit here: a missing ack is caught by the watchdog
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                            output logic [31:0] rd);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h00_0000, dat};
        do begin
            @(posedge core_clk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        logic [31:0] unused;
        wb_cycle(1'b1, adr, dat, unused);
    endtask

    task automatic rd(input logic [7:0] adr, output logic [31:0] dat);
        wb_cycle(1'b0, adr, 8'h00, dat);
    endtask

    // Count from n edges of one pin; the first rise comes before any fall
    task automatic ext_case(input logic [7:0] ctrl, input logic xtal, input int n,
                            input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] exp);
        logic [31:0] got;
        wr(A_CTRL, 8'h00);
        src.set_level(1'b0, 1'b0);
        src.set_level(1'b1, 1'b0);
        wr(A_HIGH, hi);
        wr(A_LOW, lo);
        if (xtal) begin
            wr(A_CTRL, 8'h08);
            repeat (20) @(posedge core_clk);
        end
        wr(A_CTRL, ctrl);
        src.set_level(xtal, 1'b1);
        src.pulse(xtal, n);
        repeat (10) @(posedge core_clk);
        wr(A_CTRL, ctrl & 8'hFE);
        rd(A_LOW, got);
        check(got, {24'h00_0000, exp});
    endtask

    initial begin
        repeat (60000) @(posedge core_clk);
        n_fail++;
        $display("mismatch at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        rd(A_CTRL, v);
        check(v, 32'h0000_0000);
        rd(A_STAT, v);
        check(v, 32'h0000_0000);
        check({31'h0, timebase_valid}, 32'h1);
        check({31'h0, crystal_output_pin_oe}, 32'h0);
        wr(8'h80, 8'hFF);
        rd(8'h80, v);
        check(v, 32'h0000_0000);
        wr(A_CTRL, 8'hFF);
        rd(A_CTRL, v);
        check(v, 32'h0000_003F);
        check({31'h0, crystal_output_pin_oe}, 32'h1);
        check({31'h0, crystal_output_pin_o}, {31'h0, ~crystal_input_pin});
        wr(A_CTRL, 8'h00);
        repeat (3) @(posedge core_clk);
        check({31'h0, crystal_output_pin_oe}, 32'h0);

        // Odd passes set the bypass bit, which the quarter clock ignores
        for (int d = 0; d < 4; d++) begin
            wr(A_HIGH, 8'h00);
            wr(A_LOW, 8'h00);
            wr(A_CTRL, 8'(d << 4) | 8'h01 | (d[0] ? 8'h04 : 8'h00));
            check({31'h0, timebase_valid}, 32'h1);
            repeat (796) @(posedge core_clk);
            wr(A_CTRL, 8'(d << 4));
            rd(A_LOW, v);
            // Phase of the quarter clock and a dropped stop tick allow slack
            total_checks++;
            if ((v >= 32'(198 >> d) && v <= 32'(202 >> d)) !== 1'b1) begin
                n_fail++;
                $display("mismatch at %0t: divide %0d count %h", $time, d, v);
            end
            repeat (40) @(posedge core_clk);
            rd(A_LOW, w);
            check(w, v);
        end

        wr(A_HIGH, 8'hFF);
        wr(A_LOW, 8'hFC);
        wr(A_CTRL, 8'h01);
        for (int i = 0; i < 200 && overflow_flag !== 1'b1; i++) @(posedge core_clk);
        wr(A_CTRL, 8'h00);
        check({31'h0, overflow_flag}, 32'h1);
        rd(A_HIGH, v);
        check(v, 32'h0000_0000);
        wr(A_STAT, 8'h01);
        rd(A_STAT, v);
        check(v, 32'h0000_0000);

        // Running count read as two bytes; low byte re-read after a carry
        wr(A_HIGH, 8'h00);
        wr(A_LOW, 8'hFE);
        wr(A_CTRL, 8'h01);
        rd(A_HIGH, v);
        rd(A_LOW, w);
        rd(A_HIGH, u);
        if (u[7:0] != v[7:0]) begin
            rd(A_LOW, w);
        end
        wr(A_CTRL, 8'h00);
        pair = {u[7:0], w[7:0]};
        total_checks++;
        if ((pair >= 16'h00FE && pair <= 16'h0108) !== 1'b1) begin
            n_fail++;
            $display("mismatch at %0t: two byte read %h", $time, pair);
        end

        ext_case(8'h03, 1'b0, 5, 8'h00, 8'h00, 8'h05);
        ext_case(8'h07, 1'b0, 5, 8'h00, 8'h00, 8'h05);
        ext_case(8'h0B, 1'b1, 4, 8'h00, 8'h00, 8'h04);
        ext_case(8'h13, 1'b0, 8, 8'h00, 8'h00, 8'h04);
        @(posedge core_clk) sleep_mode <= 1'b1;
        ext_case(8'h03, 1'b0, 5, 8'h00, 8'h00, 8'h00);
        ext_case(8'h0F, 1'b1, 3, 8'h00, 8'h00, 8'h03);
        check({31'h0, crystal_output_pin_oe}, 32'h1);
        check({31'h0, wake_request}, 32'h0);
        ext_case(8'h07, 1'b0, 5, 8'hFF, 8'hFE, 8'h03);
        check({31'h0, overflow_flag}, 32'h1);
        check({31'h0, wake_request}, 32'h1);
        check({31'h0, timebase_valid}, 32'h0);
        @(posedge core_clk) sleep_mode <= 1'b0;
        wr(A_STAT, 8'h01);
        stop_test();
    end
endmodule
`default_nettype wire
